// ---- verilog/sbgsl_pkg.sv ----
// constants for the servo brake, gear and speed logic
package sbgsl_pkg;
    localparam logic [9:0] OFS_BRAKE_ON_DELAY = 10'h154;
    localparam logic [9:0] OFS_BRAKE_OFF_DELAY = 10'h156;
    localparam logic [9:0] OFS_GEAR_NUM = 10'h158;
    localparam logic [9:0] OFS_ENC_PULSES = 10'h15c;
    localparam logic [9:0] OFS_SPEED_RANGE = 10'h15e;
    localparam logic [9:0] OFS_RSVD_A = 10'h160;
    localparam logic [9:0] OFS_RSVD_B = 10'h162;
    localparam logic [9:0] OFS_RSVD_C = 10'h164;
    localparam logic [9:0] OFS_RSVD_D = 10'h166;
    localparam logic [9:0] OFS_REGEN_RES = 10'h168;
    localparam logic [9:0] OFS_GEAR_DEN = 10'h180;
    localparam logic [9:0] OFS_ZERO_SPEED = 10'h184;
    localparam logic [9:0] OFS_ENC_SPEED_LIMIT = 10'h188;
    localparam logic [9:0] OFS_CONTROL = 10'h18c;
    localparam logic [9:0] OFS_STATUS = 10'h190;
    localparam logic [9:0] OFS_IRQ_STATUS = 10'h194;
    localparam logic [9:0] OFS_IRQ_MASK = 10'h198;
    localparam logic [9:0] OFS_GEAR_ALT0 = 10'h19c;
    localparam logic [9:0] OFS_GEAR_ALT1 = 10'h1a0;
    localparam logic [9:0] OFS_GEAR_ALT2 = 10'h1a4;
    localparam logic [15:0] RST_BRAKE_ON_DELAY = 16'h0000;
    localparam logic [15:0] RST_BRAKE_OFF_DELAY = 16'h0000;
    localparam logic [31:0] RST_GEAR_NUM = 32'h0000_0010;
    localparam logic [31:0] RST_GEAR_DEN = 32'h0000_000a;
    localparam logic [31:0] RST_ENC_PULSES = 32'h0000_09c4;
    localparam logic [15:0] RST_SPEED_RANGE = 16'h000a;
    localparam logic [15:0] RST_REGEN_RES = 16'h0064;
    localparam logic [15:0] RST_ZERO_SPEED = 16'h0064;
    localparam logic [15:0] RST_ENC_SPEED_LIMIT = 16'h1388;
    localparam logic [31:0] GEAR_NUM_MAX = 32'h03ff_ffff;
    localparam logic [31:0] GEAR_DEN_MAX = 32'h7fff_ffff;
    localparam logic [31:0] ENC_PULSES_MIN = 32'h0000_0004;
    localparam logic [31:0] ENC_PULSES_MAX = 32'h0000_9c40;
    localparam logic [15:0] BRAKE_ON_MAX = 16'h03e8;
    localparam logic [15:0] SPEED_RANGE_MAX = 16'h012c;
    localparam logic [15:0] REGEN_MIN = 16'h000a;
    localparam logic [15:0] REGEN_MAX = 16'h02ee;
    localparam logic [7:0] EXCLUDED_FAULT_CODE = 8'h16;
    localparam logic [7:0] SPEED_REACHED_DO_CODE = 8'h19;
    localparam int CLK_HZ = 40_000_000;
    localparam int MS_PER_S = 1000;
    localparam logic [15:0] CYCLES_PER_MS = 16'(CLK_HZ / MS_PER_S);
    // control register bits
    localparam int CTL_SERVO_ON = 0;
    localparam int CTL_PULSE_MODE = 1;
    localparam int CTL_GEAR_SEL_LO = 2;
    // status and interrupt bits
    localparam int ST_BRAKE = 0;
    localparam int ST_SPEED_OK = 1;
    localparam int ST_ENC_FAULT = 2;
    localparam int ST_ZERO_SPEED = 3;
    localparam int ST_WR_REFUSED = 4;
    localparam int IRQ_W = 4;
    typedef enum logic [1:0] {
        BRK_ENGAGED = 2'b00,
        BRK_ON_WAIT = 2'b01,
        BRK_RELEASED = 2'b10,
        BRK_OFF_WAIT = 2'b11
    } sbgsl_brake_type;
endpackage

// ---- verilog/sbgsl_ms_timer.sv ----
// millisecond timer counting down a programmed delay
`timescale 1ns/1ps
module sbgsl_ms_timer
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic start,
    input wire logic [15:0] delay_ms,
    output logic done
);
    import sbgsl_pkg::*;
    logic [15:0] pre_r;
    logic [15:0] ms_r;
    logic run_r;

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pre_r <= 16'h0000;
            ms_r <= 16'h0000;
            run_r <= 1'b0;
        end
        else if (start)
        begin
            pre_r <= CYCLES_PER_MS - 16'h0001;
            ms_r <= delay_ms;
            run_r <= 1'b1;
        end
        else if (run_r && ms_r != 16'h0000)
        begin
            if (pre_r == 16'h0000)
            begin
                pre_r <= CYCLES_PER_MS - 16'h0001;
                ms_r <= ms_r - 16'h0001;
            end
            else
            begin
                pre_r <= pre_r - 16'h0001;
            end
        end
    end

    assign done = run_r && ms_r == 16'h0000 && !start;
endmodule // sbgsl_ms_timer

// ---- verilog/sbgsl_top.sv ----
// brake, gear, encoder output and speed-reached logic
// Notes on behaviour
// - release brake after on-delay following servo-on
// - engage brake after signed off-delay on servo-off
// - zero speed during off-delay engages brake early
// - off-delay expiry engages brake regardless of speed
// - fault (except EXCLUDED_FAULT_CODE) or estop servo-off clamps negative delay
// - hold gear numerator, alternates selectable
// - hold gear denominator
// - pulse mode: numerator writes only when servo on
// - pulse mode: denominator writes refused when servo on
// - emit programmed encoder pulses per revolution
// - encoder fault on error or overspeed
// - speed reached when error within range
// - error uses unramped user speed command
// - zero range forces speed reached off
// - store regen resistance within range
// - zero speed when at or below range
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
module sbgsl_top
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [9:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic fault_active,
    input wire logic [7:0] fault_code,
    input wire logic emergency_stop_input,
    input wire logic encoder_error,
    input wire logic [15:0] motor_speed,
    input wire logic [15:0] user_speed_cmd,
    input wire logic [15:0] feedback_speed,
    input wire logic pulse_in,
    input wire logic enc_tick,
    output logic brake_release_output,
    output logic speed_reached_output,
    output logic zero_speed_signal,
    output logic encoder_output_fault,
    output logic pos_cmd_pulse,
    output logic enc_out_pulse,
    output logic irq
);
    import sbgsl_pkg::*;

    logic [15:0] brake_on_delay_r;
    logic [15:0] brake_off_delay_r;
    logic [31:0] gear_num_r [4];
    logic [31:0] gear_den_r;
    logic [31:0] enc_pulses_r;
    logic [15:0] speed_range_r;
    logic [15:0] regen_res_r;
    logic [15:0] zero_speed_r;
    logic [15:0] enc_limit_r;
    logic [3:0] control_r;
    logic [IRQ_W-1:0] irq_status_r;
    logic [IRQ_W-1:0] irq_mask_r;
    logic refused_r;
    sbgsl_brake_type brake_state_r;
    sbgsl_brake_type brake_state_nxt;
    logic servo_on_d_r;
    logic timer_start;
    logic timer_done;
    logic [15:0] timer_delay;
    logic servo_on;
    logic pos_mode;
    logic [1:0] gear_sel;
    logic wr_num_ok;
    logic wr_den_ok;
    logic fault_stop;
    logic [15:0] off_delay_eff;
    logic speed_ok_raw;
    logic enc_fault_raw;
    logic [15:0] speed_err;
    logic [IRQ_W-1:0] irq_event;

    assign servo_on = control_r[CTL_SERVO_ON];
    assign pos_mode = control_r[CTL_PULSE_MODE];
    assign gear_sel = control_r[CTL_GEAR_SEL_LO+1:CTL_GEAR_SEL_LO];
    assign wr_num_ok = !pos_mode || servo_on;
    assign wr_den_ok = !(pos_mode && servo_on);

    // out-of-range writes are ignored, not clipped
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            brake_on_delay_r <= RST_BRAKE_ON_DELAY;
            brake_off_delay_r <= RST_BRAKE_OFF_DELAY;
            gear_num_r[0] <= RST_GEAR_NUM;
            gear_num_r[1] <= RST_GEAR_NUM;
            gear_num_r[2] <= RST_GEAR_NUM;
            gear_num_r[3] <= RST_GEAR_NUM;
            gear_den_r <= RST_GEAR_DEN;
            enc_pulses_r <= RST_ENC_PULSES;
            speed_range_r <= RST_SPEED_RANGE;
            regen_res_r <= RST_REGEN_RES;
            zero_speed_r <= RST_ZERO_SPEED;
            enc_limit_r <= RST_ENC_SPEED_LIMIT;
            control_r <= 4'h0;
            irq_mask_r <= '0;
            refused_r <= 1'b0;
        end
        else
        begin
            refused_r <= 1'b0;
            if (reg_wr)
            begin
                unique case (reg_addr)
                    OFS_BRAKE_ON_DELAY:
                        if (reg_wdata[15:0] <= BRAKE_ON_MAX)
                            brake_on_delay_r <= reg_wdata[15:0];
                    OFS_BRAKE_OFF_DELAY:
                        if ($signed(reg_wdata[15:0]) >= -16'sd1000
                            && $signed(reg_wdata[15:0]) <= 16'sd1000)
                            brake_off_delay_r <= reg_wdata[15:0];
                    OFS_GEAR_NUM, OFS_GEAR_ALT0, OFS_GEAR_ALT1, OFS_GEAR_ALT2:
                    begin
                        if (!wr_num_ok)
                            refused_r <= 1'b1;
                        else if (reg_wdata inside {[32'h0000_0001:GEAR_NUM_MAX]})
                        begin
                            if (reg_addr == OFS_GEAR_NUM)
                                gear_num_r[0] <= reg_wdata;
                            else if (reg_addr == OFS_GEAR_ALT0)
                                gear_num_r[1] <= reg_wdata;
                            else if (reg_addr == OFS_GEAR_ALT1)
                                gear_num_r[2] <= reg_wdata;
                            else
                                gear_num_r[3] <= reg_wdata;
                        end
                    end
                    OFS_GEAR_DEN:
                    begin
                        if (!wr_den_ok)
                            refused_r <= 1'b1;
                        else if (reg_wdata inside {[32'h0000_0001:GEAR_DEN_MAX]})
                            gear_den_r <= reg_wdata;
                    end
                    OFS_ENC_PULSES:
                        if (reg_wdata >= ENC_PULSES_MIN && reg_wdata <= ENC_PULSES_MAX)
                            enc_pulses_r <= reg_wdata;
                    OFS_SPEED_RANGE:
                        if (reg_wdata[15:0] <= SPEED_RANGE_MAX)
                            speed_range_r <= reg_wdata[15:0];
                    OFS_REGEN_RES:
                        if (reg_wdata[15:0] >= REGEN_MIN && reg_wdata[15:0] <= REGEN_MAX)
                            regen_res_r <= reg_wdata[15:0];
                    OFS_ZERO_SPEED: zero_speed_r <= reg_wdata[15:0];
                    OFS_ENC_SPEED_LIMIT: enc_limit_r <= reg_wdata[15:0];
                    OFS_CONTROL: control_r <= reg_wdata[3:0];
                    OFS_IRQ_MASK: irq_mask_r <= reg_wdata[IRQ_W-1:0];
                    default: ;
                endcase
            end
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            reg_rdata <= 32'h0000_0000;
        else if (!reg_rd)
            reg_rdata <= 32'h0000_0000;
        else
        begin
            unique case (reg_addr)
                OFS_BRAKE_ON_DELAY: reg_rdata <= 32'(brake_on_delay_r);
                OFS_BRAKE_OFF_DELAY: reg_rdata <= 32'(brake_off_delay_r);
                OFS_GEAR_NUM: reg_rdata <= gear_num_r[0];
                OFS_GEAR_ALT0: reg_rdata <= gear_num_r[1];
                OFS_GEAR_ALT1: reg_rdata <= gear_num_r[2];
                OFS_GEAR_ALT2: reg_rdata <= gear_num_r[3];
                OFS_GEAR_DEN: reg_rdata <= gear_den_r;
                OFS_ENC_PULSES: reg_rdata <= enc_pulses_r;
                OFS_SPEED_RANGE: reg_rdata <= 32'(speed_range_r);
                OFS_REGEN_RES: reg_rdata <= 32'(regen_res_r);
                OFS_ZERO_SPEED: reg_rdata <= 32'(zero_speed_r);
                OFS_ENC_SPEED_LIMIT: reg_rdata <= 32'(enc_limit_r);
                OFS_CONTROL: reg_rdata <= 32'(control_r);
                OFS_STATUS: reg_rdata <= 32'({zero_speed_signal,
                    encoder_output_fault, speed_reached_output, brake_release_output});
                OFS_IRQ_STATUS: reg_rdata <= 32'(irq_status_r);
                OFS_IRQ_MASK: reg_rdata <= 32'(irq_mask_r);
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end
    end

    // speed comparisons; speeds are unsigned magnitudes
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            zero_speed_signal <= 1'b0;
            speed_reached_output <= 1'b0;
            encoder_output_fault <= 1'b0;
        end
        else
        begin
            zero_speed_signal <= motor_speed <= zero_speed_r;
            speed_reached_output <= speed_ok_raw;
            encoder_output_fault <= enc_fault_raw;
        end
    end

    // the user command, not the ramped loop command, feeds the error
    assign speed_err = (user_speed_cmd >= feedback_speed) ?
        user_speed_cmd - feedback_speed : feedback_speed - user_speed_cmd;
    assign speed_ok_raw = speed_range_r != 16'h0000
        && speed_err <= speed_range_r;
    assign enc_fault_raw = encoder_error || motor_speed > enc_limit_r;

    // brake sequencer
    assign fault_stop = (fault_active && fault_code != EXCLUDED_FAULT_CODE)
        || emergency_stop_input;
    // a negative off-delay only means early engage for a normal stop
    assign off_delay_eff = brake_off_delay_r[15] ? 16'h0000 : brake_off_delay_r;
    assign timer_delay = servo_on ? brake_on_delay_r : off_delay_eff;
    assign timer_start = servo_on != servo_on_d_r;

    sbgsl_ms_timer u_timer
    (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .start(timer_start),
        .delay_ms(timer_delay),
        .done(timer_done)
    );

    always_comb
    begin
        brake_state_nxt = brake_state_r;
        unique case (brake_state_r)
            BRK_ENGAGED:
                if (servo_on)
                    brake_state_nxt = BRK_ON_WAIT;
            BRK_ON_WAIT:
                if (!servo_on)
                    brake_state_nxt = BRK_ENGAGED;
                else if (timer_done)
                    brake_state_nxt = BRK_RELEASED;
            BRK_RELEASED:
                if (!servo_on)
                begin
                    if (brake_off_delay_r[15] && !fault_stop)
                        brake_state_nxt = BRK_ENGAGED;
                    else
                        brake_state_nxt = BRK_OFF_WAIT;
                end
            BRK_OFF_WAIT:
                if (servo_on)
                    brake_state_nxt = BRK_ON_WAIT;
                else if (zero_speed_signal)
                    brake_state_nxt = BRK_ENGAGED;
                else if (timer_done)
                    brake_state_nxt = BRK_ENGAGED;
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            brake_state_r <= BRK_ENGAGED;
            servo_on_d_r <= 1'b0;
        end
        else
        begin
            brake_state_r <= brake_state_nxt;
            servo_on_d_r <= servo_on;
        end
    end

    assign brake_release_output = brake_state_r == BRK_RELEASED
        || brake_state_r == BRK_OFF_WAIT;

    // gear: add N per input pulse, emit one per M
    logic [32:0] gear_acc_r;
    logic [32:0] gear_sum;
    assign gear_sum = gear_acc_r + (pulse_in ? {1'b0, gear_num_r[gear_sel]} : 33'h0);
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            gear_acc_r <= '0;
            pos_cmd_pulse <= 1'b0;
        end
        else if (gear_sum >= {1'b0, gear_den_r})
        begin
            // one output per cycle; no ratio bound, excess stays in gear_acc_r as backlog
            gear_acc_r <= gear_sum - {1'b0, gear_den_r};
            pos_cmd_pulse <= 1'b1;
        end
        else
        begin
            gear_acc_r <= gear_sum;
            pos_cmd_pulse <= 1'b0;
        end
    end

    // encoder output: enc_tick is a 1/65536-revolution step
    logic [32:0] enc_acc_r;
    logic [32:0] enc_sum;
    assign enc_sum = enc_acc_r + (enc_tick ? {1'b0, enc_pulses_r} : 33'h0);
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            enc_acc_r <= '0;
            enc_out_pulse <= 1'b0;
        end
        else if (enc_sum >= 33'h0_0001_0000)
        begin
            enc_acc_r <= enc_sum - 33'h0_0001_0000;
            enc_out_pulse <= !encoder_output_fault;
        end
        else
        begin
            enc_acc_r <= enc_sum;
            enc_out_pulse <= 1'b0;
        end
    end

    // sticky interrupt status; set wins over the read clear
    assign irq_event[ST_BRAKE] = brake_state_r != brake_state_nxt;
    assign irq_event[ST_SPEED_OK] = speed_ok_raw && !speed_reached_output;
    assign irq_event[ST_ENC_FAULT] = enc_fault_raw && !encoder_output_fault;
    assign irq_event[ST_ZERO_SPEED] = refused_r;
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            irq_status_r <= '0;
        else if (reg_rd && reg_addr == OFS_IRQ_STATUS)
            irq_status_r <= irq_event;
        else
            irq_status_r <= irq_status_r | irq_event;
    end
    assign irq = |(irq_status_r & irq_mask_r);
endmodule // sbgsl_top

// ---- tb/sbgsl_assertions.sv ----
// port-level checks of brake, speed and encoder outputs
`timescale 1ns/1ps
module sbgsl_assertions
    import sbgsl_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [9:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic [15:0] motor_speed,
    input wire logic [15:0] user_speed_cmd,
    input wire logic [15:0] feedback_speed,
    input wire logic encoder_error,
    input wire logic brake_release_output,
    input wire logic speed_reached_output,
    input wire logic zero_speed_signal,
    input wire logic encoder_output_fault,
    input wire logic enc_out_pulse
);
    logic [15:0] rng_r;
    logic son_r;
    logic [15:0] err;
    assign err = user_speed_cmd > feedback_speed ? user_speed_cmd - feedback_speed :
        feedback_speed - user_speed_cmd;
    // zero-speed range taken as its reset value
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rng_r <= RST_SPEED_RANGE;
            son_r <= 1'b0;
        end
        else if (reg_wr && reg_addr == OFS_SPEED_RANGE && reg_wdata <= 32'h012c)
            rng_r <= reg_wdata[15:0];
        else if (reg_wr && reg_addr == OFS_CONTROL)
            son_r <= reg_wdata[CTL_SERVO_ON];
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    sequence s_slow;
        (motor_speed <= RST_ZERO_SPEED) [*3];
    endsequence
    sequence s_fast;
        (motor_speed > RST_ZERO_SPEED) [*3];
    endsequence
    sequence s_near;
        (err <= rng_r && rng_r != 16'h0) [*3];
    endsequence
    zero_on_a: assert property (s_slow |-> zero_speed_signal)
        else $error("zero flag low");
    zero_off_a: assert property (s_fast |-> !zero_speed_signal)
        else $error("zero flag high");
    speed_hit_a: assert property (s_near |-> speed_reached_output)
        else $error("no speed reached");
    speed_miss_a: assert property ((err > rng_r) [*3] |-> !speed_reached_output)
        else $error("speed reached early");
    speed_zero_a: assert property ((rng_r == 16'h0) [*3] |-> !speed_reached_output)
        else $error("speed reached at zero range");
    enc_fault_a: assert property (encoder_error [*3] |-> encoder_output_fault)
        else $error("no encoder fault");
    enc_quiet_a: assert property (encoder_output_fault && $past(encoder_output_fault)
        |-> !enc_out_pulse) else $error("pulse in fault");
    brake_hold_a: assert property ($rose(brake_release_output) |-> son_r)
        else $error("release without servo on");
    brake_stop_a: assert property ((!son_r && zero_speed_signal) [*4]
        |-> !brake_release_output) else $error("brake open at rest");
endmodule // sbgsl_assertions
bind sbgsl_top sbgsl_assertions u_chk (.clk_sys(clk_sys), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .motor_speed(motor_speed),
    .user_speed_cmd(user_speed_cmd), .feedback_speed(feedback_speed),
    .encoder_error(encoder_error), .brake_release_output(brake_release_output),
    .speed_reached_output(speed_reached_output), .zero_speed_signal(zero_speed_signal),
    .encoder_output_fault(encoder_output_fault), .enc_out_pulse(enc_out_pulse));

// ---- tb/sbgsl_motor_model.sv ----
// far-side motor: speed slews to a target, encoder ticks while spinning
`timescale 1ns/1ps
module sbgsl_motor_model
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic brake_release_output,
    input wire logic [15:0] target_speed,
    input wire logic spin,
    output logic [15:0] motor_speed,
    output logic enc_tick
);
    logic [15:0] tgt;
    // a held brake drags the shaft to rest
    assign tgt = brake_release_output ? target_speed : 16'h0;
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            {motor_speed, enc_tick} <= 17'h0_0000;
        else if (motor_speed + 16'h100 < tgt)
            {motor_speed, enc_tick} <= {motor_speed + 16'h100, spin};
        else if (motor_speed > tgt + 16'h100)
            {motor_speed, enc_tick} <= {motor_speed - 16'h100, spin};
        else
            {motor_speed, enc_tick} <= {tgt, spin};
    end
endmodule // sbgsl_motor_model

// ---- tb/sbgsl_top_bench.sv ----
// self-checking bench
`timescale 1ns/1ps
module sbgsl_top_bench;
    import sbgsl_pkg::*;
    logic clk_sys = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, fault_active = 0;
    logic emergency_stop_input = 0, encoder_error = 0, pulse_in = 0, spin = 0;
    logic [9:0] reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata, rd_v, seed = 32'hc8f1;
    logic [7:0] fault_code = 0;
    logic [15:0] user_speed_cmd = 0, target = 0, motor_speed;
    logic brake_release_output, speed_reached_output, zero_speed_signal, enc_tick;
    logic encoder_output_fault, pos_cmd_pulse, enc_out_pulse, irq;
    int fails = 0, n_tests = 0, n_pos = 0, n_enc = 0, base, t;
    bit son = 0, pp = 0;
    int mdl [int] = '{OFS_BRAKE_ON_DELAY: 0, OFS_BRAKE_OFF_DELAY: 0, OFS_GEAR_NUM: 16,
        OFS_ENC_PULSES: 2500, OFS_SPEED_RANGE: 10, OFS_REGEN_RES: 100, OFS_GEAR_DEN: 10};
    int rows [$] = '{340, 1001, 340, 1000, 340, 0, 342, 64535,
        342, 64536, 342, 0, 348, 3, 348, 40001, 348, 40000,
        348, 40, 350, 301, 350, 300, 350, 20, 360, 9, 360, 751,
        360, 750, 344, 0, 344, 32'h0400_0000, 384, 0,
        384, 32'h8000_0000, 384, 2, 344, 3};
    always #12.5 clk_sys = ~clk_sys;
    sbgsl_motor_model u_motor (.clk_sys(clk_sys), .reset_n(reset_n),
        .brake_release_output(brake_release_output), .target_speed(target), .spin(spin),
        .motor_speed(motor_speed), .enc_tick(enc_tick));
    sbgsl_top u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .fault_active(fault_active), .fault_code(fault_code),
        .emergency_stop_input(emergency_stop_input), .encoder_error(encoder_error),
        .motor_speed(motor_speed), .user_speed_cmd(user_speed_cmd),
        .feedback_speed(motor_speed), .pulse_in(pulse_in), .enc_tick(enc_tick),
        .brake_release_output(brake_release_output), .speed_reached_output(speed_reached_output),
        .zero_speed_signal(zero_speed_signal), .encoder_output_fault(encoder_output_fault),
        .pos_cmd_pulse(pos_cmd_pulse), .enc_out_pulse(enc_out_pulse), .irq(irq));
    always @(posedge clk_sys)
    begin
        n_pos += (pos_cmd_pulse === 1'b1);
        n_enc += (enc_out_pulse === 1'b1);
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic bit legal(int a, int d);
        case (a)
            OFS_BRAKE_ON_DELAY: return d <= 1000;
            OFS_BRAKE_OFF_DELAY: return $signed(d[15:0]) inside {[-1000:1000]};
            OFS_GEAR_NUM: return d inside {[1:32'h03ff_ffff]} && !(pp && !son);
            OFS_GEAR_DEN: return d > 0 && !(pp && son);
            OFS_ENC_PULSES: return d inside {[4:40000]};
            OFS_SPEED_RANGE: return d <= 300;
            default: return d inside {[10:750]};
        endcase
    endfunction
    function automatic bit spd(int u, int f, int r);
        return r != 0 && (u > f ? u - f : f - u) <= r;
    endfunction
    task automatic end_of_test();
        $display("tests %0d fails %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(logic [9:0] a, logic [31:0] d);
        @(posedge clk_sys);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [9:0] a);
        @(posedge clk_sys);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 rd_v = reg_rdata;
    endtask
    task automatic wm(int a, int d);
        wr(a[9:0], d);
        if (legal(a, d))
            mdl[a] = d;
        rd(a[9:0]);
        chk(rd_v, mdl[a]);
    endtask
    task automatic wait_brk(logic v, int lim);
        repeat (lim)
            if (brake_release_output !== v)
                @(posedge clk_sys);
        #1 chk(brake_release_output, v);
        if (brake_release_output !== v)
            end_of_test();
    endtask
    initial
    begin
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        wr(OFS_RSVD_B, 32'hffff_ffff);
        wr(10'h3fc, 32'hffff_ffff);
        foreach (mdl[k])
        begin
            rd(k[9:0]);
            chk(rd_v, mdl[k]);
        end
        for (int k = 0; k < 5; k++)
        begin
            rd(k < 4 ? 10'(OFS_RSVD_A + 2 * k) : 10'h3fc);
            chk(rd_v, 0);
        end
        for (int k = 0; k < rows.size(); k += 2)
            wm(rows[k], rows[k + 1]);
        rd(OFS_IRQ_STATUS);
        wr(OFS_IRQ_MASK, 32'h8);
        pp = 1;
        wr(OFS_CONTROL, 32'h2);
        wm(OFS_GEAR_NUM, 5);
        chk(irq, 1);
        rd(OFS_IRQ_STATUS);
        chk(rd_v & 32'h8, 32'h8);
        chk(irq, 0);
        wm(OFS_GEAR_DEN, 4);
        son = 1;
        wr(OFS_CONTROL, 32'h3);
        wait_brk(1, 8);
        wm(OFS_GEAR_DEN, 2);
        wm(OFS_GEAR_NUM, 6);
        wr(OFS_IRQ_MASK, 32'hf);
        wm(OFS_GEAR_DEN, 3);
        chk(irq, 1);
        for (int i = 0; i < 24; i++)
        begin
            if (i == 16)
                wm(OFS_SPEED_RANGE, 0);
            @(posedge clk_sys);
            t = xs() % 4000;
            target <= 16'(t);
            user_speed_cmd <= 16'(t + xs() % 81 - 40);
            repeat (24) @(posedge clk_sys);
            #1 chk(speed_reached_output, spd(user_speed_cmd, motor_speed, mdl[10'h15e]));
        end
        for (int s = 0; s < 2; s++)
        begin
            wr(OFS_CONTROL, 32'h3 | s << 2);
            base = n_pos;
            for (int p = 0; p < 801; p++)
            begin
                @(posedge clk_sys);
                pulse_in <= p % 8 == 1;
            end
            repeat (20) @(posedge clk_sys);
            chk(n_pos - base, s ? 400 : 150);
        end
        base = n_enc;
        @(posedge clk_sys);
        spin <= 1'b1;
        repeat (8192) @(posedge clk_sys);
        spin <= 1'b0;
        repeat (8) @(posedge clk_sys);
        chk(n_enc - base, 5);
        target <= 16'hbb8;
        {son, pp} = 0;
        wr(OFS_CONTROL, 32'h0);
        wait_brk(0, 8);
        wm(OFS_BRAKE_ON_DELAY, 1);
        wr(OFS_CONTROL, 32'h1);
        repeat (39990) @(posedge clk_sys);
        #1 chk(brake_release_output, 0);
        wait_brk(1, 40);
        wm(OFS_BRAKE_OFF_DELAY, 1);
        wr(OFS_CONTROL, 32'h0);
        repeat (39990) @(posedge clk_sys);
        #1 chk(brake_release_output, 1);
        wait_brk(0, 40);
        wm(OFS_BRAKE_ON_DELAY, 0);
        wr(OFS_CONTROL, 32'h1);
        wait_brk(1, 8);
        repeat (20) @(posedge clk_sys);
        wr(OFS_CONTROL, 32'h0);
        target <= 16'h0;
        wait_brk(0, 40);
        wm(OFS_BRAKE_OFF_DELAY, 16'hffff);
        for (int c = 0; c < 3; c++)
        begin
            target <= 16'hbb8;
            wr(OFS_CONTROL, 32'h1);
            wait_brk(1, 8);
            @(posedge clk_sys);
            emergency_stop_input <= (c == 0);
            fault_active <= (c == 1);
            fault_code <= 8'h21;
            wr(OFS_CONTROL, 32'h0);
            wait_brk(0, 4);
            emergency_stop_input <= 1'b0;
            fault_active <= 1'b0;
        end
        @(posedge clk_sys);
        encoder_error <= 1'b1;
        repeat (4) @(posedge clk_sys);
        #1 chk(encoder_output_fault, 1);
        rd(OFS_IRQ_STATUS);
        chk(rd_v & 32'h4, 32'h4);
        end_of_test();
    end
endmodule // sbgsl_top_bench
